// File: sbrb_pkg.sv
// Package: shared types and constants for the snoop and bus request blocking block
package sbrb_pkg;

    // ****************************************************************
    // Timing constants
    // ****************************************************************
    localparam int unsigned SBRB_CLK_PERIOD_NS = 10;
    localparam int unsigned SBRB_SNOOP_LAT_CYC = 2;        // Request sample to status drive
    localparam logic [1:0] SBRB_SNOOP_LAT = 2'h2;
    localparam logic [1:0] SBRB_LAT_RESET = 2'h0;

    // ****************************************************************
    // Snoop status field layout and values
    // ****************************************************************
    localparam int unsigned SBRB_STAT_SHARED = 0;
    localparam int unsigned SBRB_STAT_RETRY = 1;
    localparam int unsigned SBRB_STAT_COPYBACK = 2;
    localparam logic [2:0] SBRB_STAT_NONE = 3'h0;
    localparam logic [2:0] SBRB_STAT_HIT = 3'h1;
    localparam logic [2:0] SBRB_STAT_COLLIDE = 3'h2;
    localparam logic [2:0] SBRB_STAT_MOD_HIT = 3'h7;

    // ****************************************************************
    // Master sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        SBRB_IDLE = 3'b000,
        SBRB_REQ = 3'b001,
        SBRB_ADDR = 3'b010,
        SBRB_WAIT_DATA = 3'b011,
        SBRB_DATA = 3'b100
    } sbrb_mst_state_t;

    // System bus samples, all active high inside the block
    typedef struct packed {
        logic address_retry;
        logic addr_bus_busy;
        logic bus_grant;
        logic data_bus_grant;
        logic address_ack;
        logic transfer_ack;
        logic snoop_request;
        logic global_attr;
        logic addr_bus_busy_other;
    } sbrb_sys_in_t;

    // Cache lookup answer for a snooped address
    typedef struct packed {
        logic valid;
        logic main_hit;
        logic modified;
        logic collision;
    } sbrb_lookup_t;

    // Master request from the cache side
    typedef struct packed {
        logic valid;
        logic global_attr;
        logic split_bus;
        logic last_beat;
    } sbrb_req_t;

endpackage : sbrb_pkg

// File: sbrb_block_filter.sv
// Bus request blocking filter driven by address retry and address-bus-busy
`timescale 1ns/100ps
`default_nettype none
module sbrb_block_filter (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic address_retry_in,
    input wire logic addr_bus_busy_in,
    output logic blocked_out,
    output logic block_start_out
);
    import sbrb_pkg::*;

    logic abb_prev_q;
    logic abb_prev_d;
    logic blocked_q;
    logic blocked_d;
    logic start;

    // ****************************************************************
    // Blocking decision
    // ****************************************************************
    // Retry only counts when busy was high the cycle before; this masks the late
    // negation of the snooper's retry right after busy drops.
    always_comb begin
        abb_prev_d = addr_bus_busy_in;
        start = address_retry_in && abb_prev_q;
        blocked_d = blocked_q;
        if (start) begin
            blocked_d = 1'b1;
        end else if (!address_retry_in || !abb_prev_q) begin
            blocked_d = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            abb_prev_q <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            abb_prev_q <= abb_prev_d;
            blocked_q <= blocked_d;
        end
    end

    assign blocked_out = blocked_q;
    assign block_start_out = start;
endmodule : sbrb_block_filter
`default_nettype wire

// File: sbrb_snoop_resp.sv
// Snoop response: status timing, hold and copyback request trigger
`timescale 1ns/100ps
`default_nettype none
module sbrb_snoop_resp (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire sbrb_pkg::sbrb_sys_in_t sys_in,
    input wire sbrb_pkg::sbrb_lookup_t lookup_in,
    output logic [2:0] status_d_out,
    output logic copyback_due_out,
    output logic snoop_capture_out
);
    import sbrb_pkg::*;

    logic [1:0] lat_q;
    logic [1:0] lat_d;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic sr_prev_q;
    logic sr_prev_d;
    logic cb_q;
    logic cb_d;
    logic capture;

    // ****************************************************************
    // Snoop timing
    // ****************************************************************
    // Request must be negated between snoops, so only its rising sample counts.
    always_comb begin
        capture = sys_in.snoop_request && sys_in.global_attr && !sr_prev_q;
        sr_prev_d = sys_in.snoop_request;
        lat_d = lat_q;
        stat_d = stat_q;
        cb_d = 1'b0;
        if (capture) begin
            lat_d = SBRB_SNOOP_LAT - 2'h1;
        end else if (lat_q != SBRB_LAT_RESET) begin
            lat_d = lat_q - 2'h1;
        end
        // Status appears two cycles after the sampled request
        if (lat_q == 2'h1) begin
            if (lookup_in.collision) begin
                stat_d = SBRB_STAT_COLLIDE;
            end else if (lookup_in.main_hit && lookup_in.modified) begin
                stat_d = SBRB_STAT_MOD_HIT;
                cb_d = 1'b1;
            end else if (lookup_in.main_hit) begin
                stat_d = SBRB_STAT_HIT;
            end else begin
                stat_d = SBRB_STAT_NONE;
            end
        end else if (!sys_in.addr_bus_busy) begin
            stat_d = SBRB_STAT_NONE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            lat_q <= SBRB_LAT_RESET;
            stat_q <= SBRB_STAT_NONE;
            sr_prev_q <= 1'b0;
            cb_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
            stat_q <= stat_d;
            sr_prev_q <= sr_prev_d;
            cb_q <= cb_d;
        end
    end

    assign status_d_out = stat_d;
    assign copyback_due_out = cb_d;
    assign snoop_capture_out = capture;
endmodule : sbrb_snoop_resp
`default_nettype wire

// File: snoop_bus_request_blocking.sv
// Top: system bus snoop response and bus request blocking of a secondary cache
// ****************************************************************
// Overview of operation
// - Retry after busy: drop request, ignore grant
// - Stay blocked until retry negated or busy idle
// - No blocking when busy negated previous cycle
// - Ignore retry in cycle after busy negated
// - Drive snoop status two cycles after request
// - Non-global transactions are never snooped
// - Snoop miss leaves all status negated
// - Modified main hit: all status, copyback
// - Full speed: request one cycle after status
// - Half speed: request with retry status
// - Copyback issued with global attribute negated
// - Negate retry status after busy negated
// - Split bus: sample retry after address ack
// - Unqualified retry keeps bus; qualified releases it
// - Hold busy until address ack or end
// - Qualified grant: start, attributes, busy, drop request
// - Qualified data grant: data busy, data tenure
// - Retried master re-requests after copyback owner
// - Address bus reusable during other's data tenure
// - Snoop only with request and global both
// - Snoop status held until busy negated
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module snoop_bus_request_blocking (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic half_speed_in,
    input wire sbrb_pkg::sbrb_sys_in_t sys_in,
    input wire sbrb_pkg::sbrb_lookup_t lookup_in,
    input wire sbrb_pkg::sbrb_req_t req_in,
    output logic sys_bus_request_out,
    output logic sys_transfer_start_out,
    output logic sys_global_attr_out,
    output logic sys_addr_bus_busy_out,
    output logic sys_data_bus_busy_out,
    output logic [2:0] snoop_status_outputs_out,
    output logic retried_out,
    output logic copyback_active_out,
    output logic done_out
);
    import sbrb_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    sbrb_mst_state_t state_q;
    sbrb_mst_state_t state_d;
    logic blocked;
    logic block_start;
    logic [2:0] stat_d;
    logic cb_due;
    logic cb_pend_q;
    logic cb_pend_d;
    logic cb_active_q;
    logic cb_active_d;
    logic split_q;
    logic split_d;
    logic aack_seen_q;
    logic aack_seen_d;
    logic retried_q;
    logic retried_d;
    logic wait_owner_q;
    logic wait_owner_d;
    logic br_q;
    logic br_d;
    logic ts_q;
    logic ts_d;
    logic gbl_q;
    logic gbl_d;
    logic abb_q;
    logic abb_d;
    logic dbb_q;
    logic dbb_d;
    logic done_q;
    logic done_d;
    logic [2:0] stat_q;
    logic want_bus;
    logic grant_ok;
    logic dgrant_ok;
    logic retry_hit;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    sbrb_block_filter u_filter (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .address_retry_in(sys_in.address_retry),
        .addr_bus_busy_in(sys_in.addr_bus_busy),
        .blocked_out(blocked),
        .block_start_out(block_start)
    );

    sbrb_snoop_resp u_snoop (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .sys_in(sys_in),
        .lookup_in(lookup_in),
        .status_d_out(stat_d),
        .copyback_due_out(cb_due),
        .snoop_capture_out()
    );

    // Address bus is qualified only when no other master holds it
    function automatic logic qualified(input logic grant, input logic busy_other);
        qualified = grant && !busy_other;
    endfunction : qualified

    // ****************************************************************
    // Master sequencer
    // ****************************************************************
    // Grant is evaluated only in the request state, ahead of the want check, and only when not blocked;
    // a grant arriving during blocking is simply disregarded.
    always_comb begin
        state_d = state_q;
        cb_pend_d = cb_pend_q || cb_due;
        cb_active_d = cb_active_q;
        split_d = split_q;
        aack_seen_d = aack_seen_q;
        retried_d = retried_q;
        wait_owner_d = wait_owner_q;
        ts_d = 1'b0;
        gbl_d = gbl_q;
        abb_d = abb_q;
        dbb_d = dbb_q;
        done_d = 1'b0;
        want_bus = cb_pend_q || cb_due || (req_in.valid && !wait_owner_q);
        grant_ok = qualified(sys_in.bus_grant, sys_in.addr_bus_busy_other)
                   && !blocked && !block_start;
        dgrant_ok = qualified(sys_in.data_bus_grant, dbb_q);
        // Retry is qualified by address ack on a split bus, one cycle later
        retry_hit = sys_in.address_retry &&
                    (split_q ? aack_seen_q : 1'b1);
        // Retried master waits for the copyback owner to take the bus
        if (wait_owner_q && sys_in.addr_bus_busy_other) begin
            wait_owner_d = 1'b0;
        end
        case (state_q)
            SBRB_IDLE: begin
                if (want_bus) begin
                    state_d = SBRB_REQ;
                end
            end
            SBRB_REQ: begin
                if (grant_ok) begin
                    state_d = SBRB_ADDR;
                    ts_d = 1'b1;
                    abb_d = 1'b1;
                    cb_active_d = cb_pend_q;
                    cb_pend_d = cb_due;                            // New copyback stays pending
                    split_d = req_in.split_bus;
                    aack_seen_d = 1'b0;
                    gbl_d = cb_pend_q ? 1'b0 : req_in.global_attr;
                end else if (!want_bus) begin
                    state_d = SBRB_IDLE;
                end
            end
            SBRB_ADDR: begin
                aack_seen_d = sys_in.address_ack;
                if (retry_hit && !cb_active_q) begin
                    abb_d = 1'b0;
                    gbl_d = 1'b0;
                    retried_d = 1'b1;
                    wait_owner_d = 1'b1;
                    state_d = SBRB_IDLE;
                end else if (sys_in.address_ack || sys_in.transfer_ack) begin
                    abb_d = 1'b0;
                    gbl_d = 1'b0;
                    state_d = SBRB_WAIT_DATA;
                end
                if (dgrant_ok && !retry_hit) begin
                    dbb_d = 1'b1;
                    state_d = SBRB_DATA;
                end
            end
            SBRB_WAIT_DATA: begin
                // Address bus may pass to another master meanwhile
                aack_seen_d = 1'b0;
                if (split_q && aack_seen_q && sys_in.address_retry && !cb_active_q) begin
                    retried_d = 1'b1;
                    wait_owner_d = 1'b1;
                    state_d = SBRB_IDLE;
                end else if (dgrant_ok) begin
                    dbb_d = 1'b1;
                    state_d = SBRB_DATA;
                end
            end
            SBRB_DATA: begin
                abb_d = abb_q && !(sys_in.address_ack || sys_in.transfer_ack);
                if (sys_in.transfer_ack && req_in.last_beat) begin
                    dbb_d = 1'b0;
                    abb_d = 1'b0;
                    gbl_d = 1'b0;
                    done_d = 1'b1;
                    cb_active_d = 1'b0;
                    if (!cb_active_q) begin
                        retried_d = 1'b0;
                    end
                    state_d = SBRB_IDLE;
                end
            end
            default: begin
                state_d = SBRB_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Bus request output
    // ****************************************************************
    // Half speed raises request with the retry status; full speed one cycle later
    always_comb begin
        br_d = 1'b0;
        if ((state_d == SBRB_REQ) && !blocked && !block_start) begin
            br_d = 1'b1;
        end
        if (cb_due && half_speed_in) begin
            br_d = !blocked && !block_start;
        end else if (cb_due) begin
            br_d = 1'b0;
        end
        if (state_d == SBRB_ADDR) begin
            br_d = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_q <= SBRB_IDLE;
            cb_pend_q <= 1'b0;
            cb_active_q <= 1'b0;
            split_q <= 1'b0;
            aack_seen_q <= 1'b0;
            retried_q <= 1'b0;
            wait_owner_q <= 1'b0;
            br_q <= 1'b0;
            ts_q <= 1'b0;
            gbl_q <= 1'b0;
            abb_q <= 1'b0;
            dbb_q <= 1'b0;
            done_q <= 1'b0;
            stat_q <= SBRB_STAT_NONE;
        end else begin
            state_q <= state_d;
            cb_pend_q <= cb_pend_d;
            cb_active_q <= cb_active_d;
            split_q <= split_d;
            aack_seen_q <= aack_seen_d;
            retried_q <= retried_d;
            wait_owner_q <= wait_owner_d;
            br_q <= br_d;
            ts_q <= ts_d;
            gbl_q <= gbl_d;
            abb_q <= abb_d;
            dbb_q <= dbb_d;
            done_q <= done_d;
            stat_q <= stat_d;
        end
    end

    // Outputs straight from flip-flops
    assign sys_bus_request_out = br_q;
    assign sys_transfer_start_out = ts_q;
    assign sys_global_attr_out = gbl_q;
    assign sys_addr_bus_busy_out = abb_q;
    assign sys_data_bus_busy_out = dbb_q;
    assign snoop_status_outputs_out = stat_q;
    assign retried_out = retried_q;
    assign copyback_active_out = cb_active_q;
    assign done_out = done_q;
endmodule : snoop_bus_request_blocking
`default_nettype wire

// File: sbrb_monitor.sv
// Checker: snoop status timing and bus request blocking properties
`timescale 1ns/100ps
`default_nettype none
module sbrb_monitor
    import sbrb_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic half_speed_in,
    input wire sbrb_pkg::sbrb_sys_in_t sys_in,
    input wire sbrb_pkg::sbrb_lookup_t lookup_in,
    input wire sbrb_pkg::sbrb_req_t req_in,
    input wire logic sys_bus_request_out,
    input wire logic sys_transfer_start_out,
    input wire logic sys_global_attr_out,
    input wire logic sys_addr_bus_busy_out,
    input wire logic sys_data_bus_busy_out,
    input wire logic [2:0] snoop_status_outputs_out,
    input wire logic retried_out,
    input wire logic copyback_active_out,
    input wire logic done_out
);
    logic sr_q;
    logic sr_d;
    logic take;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // A snoop is taken only on a fresh request edge, a held request is ignored
    always_comb begin
        sr_d = sys_in.snoop_request;
        take = sys_in.snoop_request && sys_in.global_attr && !sr_q;
    end
    always_ff @(posedge clock_in) begin
        sr_q <= srst_in ? 1'b0 : sr_d;
    end
    AST_STAT_CAUSE: assert property ($rose(snoop_status_outputs_out != SBRB_STAT_NONE)
        |-> $past(take, 2)) else $error("status rose without a snoop two cycles before");
    AST_MISS: assert property ($past(take, 2) && !$past(lookup_in.main_hit)
        && !$past(lookup_in.collision)
        |-> snoop_status_outputs_out == SBRB_STAT_NONE) else $error("status driven on a miss");
    AST_MOD_HIT: assert property ($past(take, 2) &&
        $past(lookup_in.main_hit) && $past(lookup_in.modified) && !$past(lookup_in.collision)
        |-> snoop_status_outputs_out == SBRB_STAT_MOD_HIT) else $error("modified hit status wrong");
    AST_FULL_BR: assert property ($rose(snoop_status_outputs_out == SBRB_STAT_MOD_HIT) &&
        !half_speed_in && !sys_in.address_retry |-> !sys_bus_request_out ##1 sys_bus_request_out)
        else $error("full speed copyback request timing wrong");
    AST_HALF_BR: assert property ($rose(snoop_status_outputs_out == SBRB_STAT_MOD_HIT) &&
        half_speed_in && !sys_in.address_retry |-> sys_bus_request_out)
        else $error("half speed copyback request not with status");
    AST_HOLD: assert property (snoop_status_outputs_out != SBRB_STAT_NONE &&
        sys_in.addr_bus_busy |=> $stable(snoop_status_outputs_out)) else $error("status not held");
    AST_RELEASE: assert property (snoop_status_outputs_out != SBRB_STAT_NONE &&
        !sys_in.addr_bus_busy |=> snoop_status_outputs_out == SBRB_STAT_NONE)
        else $error("status not negated after busy low");
    AST_BLOCK: assert property (sys_in.address_retry && $past(sys_in.addr_bus_busy) &&
        !copyback_active_out |=> !sys_bus_request_out) else $error("request kept during retry");
    AST_GRANT: assert property (sys_bus_request_out && sys_in.bus_grant &&
        !sys_in.addr_bus_busy_other && !sys_in.address_retry
        |=> sys_transfer_start_out && sys_addr_bus_busy_out && !sys_bus_request_out)
        else $error("qualified grant not taken");
    AST_CB_GBL: assert property (copyback_active_out && sys_transfer_start_out
        |-> !sys_global_attr_out) else $error("copyback issued as global");
    AST_DBB: assert property ($rose(sys_data_bus_busy_out)
        |-> $past(sys_in.data_bus_grant)) else $error("data busy without data grant");
endmodule : sbrb_monitor
bind snoop_bus_request_blocking sbrb_monitor mon_u (
    .clock_in(clock_in), .srst_in(srst_in), .half_speed_in(half_speed_in), .sys_in(sys_in),
    .lookup_in(lookup_in), .req_in(req_in), .sys_bus_request_out(sys_bus_request_out),
    .sys_transfer_start_out(sys_transfer_start_out), .sys_global_attr_out(sys_global_attr_out),
    .sys_addr_bus_busy_out(sys_addr_bus_busy_out), .sys_data_bus_busy_out(sys_data_bus_busy_out),
    .snoop_status_outputs_out(snoop_status_outputs_out), .retried_out(retried_out),
    .copyback_active_out(copyback_active_out), .done_out(done_out)
);
`default_nettype wire

// File: sbrb_bus_partner.sv
// Partner model: bus arbiter and memory system on the far side of the system bus
`timescale 1ns/100ps
`default_nettype none
module sbrb_bus_partner (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic gnt_en_in,
    input wire logic [3:0] aack_dly_in,
    input wire logic bus_request_in,
    input wire logic transfer_start_in,
    input wire logic data_bus_busy_in,
    output logic bus_grant_out,
    output logic address_ack_out,
    output logic data_bus_grant_out,
    output logic transfer_ack_out
);
    logic [3:0] ack_q;
    logic pend_q;
    // Answers move half a cycle after the sampled edge; a zero delay never acknowledges
    always @(negedge clock_in) begin
        if (srst_in) begin
            ack_q <= 4'h0;
            pend_q <= 1'b0;
            bus_grant_out <= 1'b0;
            address_ack_out <= 1'b0;
            data_bus_grant_out <= 1'b0;
            transfer_ack_out <= 1'b0;
        end else begin
            bus_grant_out <= gnt_en_in && bus_request_in;
            address_ack_out <= (ack_q == 4'h1);
            ack_q <= transfer_start_in ? aack_dly_in : ack_q - 4'((ack_q != 4'h0));
            pend_q <= transfer_start_in || (pend_q && !data_bus_busy_in);
            data_bus_grant_out <= gnt_en_in && pend_q && !data_bus_busy_in;
            transfer_ack_out <= data_bus_busy_in && !transfer_ack_out;
        end
    end
endmodule : sbrb_bus_partner
`default_nettype wire

// File: snoop_bus_request_blocking_tb_top.sv
// Testbench: snoop status table, bus request blocking and retry scenarios
`timescale 1ns/100ps
`default_nettype none
module snoop_bus_request_blocking_tb_top;
    import sbrb_pkg::*;
    typedef struct packed {logic g; logic hs; sbrb_lookup_t lk; logic [2:0] st;} sbrb_row_t;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic half_speed_in = 1'b0;
    logic retry = 1'b0, sr = 1'b0, gbl = 1'b0, other = 1'b0, gnt_en = 1'b0;
    logic [3:0] aack_dly = 4'h0;
    sbrb_sys_in_t sys_in;
    sbrb_lookup_t lookup_in = '0;
    sbrb_req_t req_in = '{1'b0, 1'b0, 1'b0, 1'b1}; // Last beat set so a copyback can end
    logic br, ts, gbl_o, abb_o, dbb_o, retried, cb_act, done, gnt, aack, dgnt, ta;
    logic [2:0] stat;
    sbrb_row_t rows [6];
    sbrb_row_t r;
    int err_count = 0;
    int n_compared = 0;
    always #5 clock_in = ~clock_in;
    // Bus line of address busy is the wired sum of our drive and other masters
    always_comb sys_in = '{address_retry: retry, addr_bus_busy: abb_o | other, bus_grant: gnt,
        data_bus_grant: dgnt, address_ack: aack, transfer_ack: ta, snoop_request: sr,
        global_attr: gbl, addr_bus_busy_other: other};
    snoop_bus_request_blocking dut_u (.clock_in(clock_in), .srst_in(srst_in),
        .half_speed_in(half_speed_in), .sys_in(sys_in), .lookup_in(lookup_in), .req_in(req_in),
        .sys_bus_request_out(br), .sys_transfer_start_out(ts), .sys_global_attr_out(gbl_o),
        .sys_addr_bus_busy_out(abb_o), .sys_data_bus_busy_out(dbb_o),
        .snoop_status_outputs_out(stat), .retried_out(retried), .copyback_active_out(cb_act),
        .done_out(done));
    sbrb_bus_partner part_u (.clock_in(clock_in), .srst_in(srst_in), .gnt_en_in(gnt_en),
        .aack_dly_in(aack_dly), .bus_request_in(br), .transfer_start_in(ts),
        .data_bus_busy_in(dbb_o), .bus_grant_out(gnt), .address_ack_out(aack),
        .data_bus_grant_out(dgnt), .transfer_ack_out(ta));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    function automatic logic pick(input int s);
        case (s)
            0: return ts;
            1: return done;
            2: return br;
            default: return dbb_o;
        endcase
    endfunction : pick
    // Bounded wait at falling edges, so a hang shows as one mismatch, not a stall
    task automatic wait_for(input int s, input logic lvl);
        int i;
        for (i = 0; i < 60 && pick(s) !== lvl; i++) @(negedge clock_in);
        check(12'(pick(s)), 12'(lvl));
    endtask : wait_for
    initial begin
        #100us;
        err_count++;
        conclude();
    end
    initial begin
        rows[0] = '{1'b1, 1'b0, 4'h8, SBRB_STAT_NONE};
        rows[1] = '{1'b0, 1'b0, 4'hE, SBRB_STAT_NONE};
        rows[2] = '{1'b1, 1'b0, 4'hC, SBRB_STAT_HIT};
        rows[3] = '{1'b1, 1'b0, 4'h9, SBRB_STAT_COLLIDE};
        rows[4] = '{1'b1, 1'b0, 4'hE, SBRB_STAT_MOD_HIT};
        rows[5] = '{1'b1, 1'b1, 4'hE, SBRB_STAT_MOD_HIT};
        repeat (8) @(negedge clock_in);
        check(12'({br, ts, gbl_o, abb_o, dbb_o, stat, retried, cb_act, done}), 12'h0);
        srst_in = 1'b0;
        // Snoop table: status two cycles after request, copyback request per speed mode
        foreach (rows[i]) begin
            r = rows[i];
            half_speed_in = r.hs;
            gbl = r.g;
            lookup_in = r.lk;
            sr = 1'b1;
            other = 1'b1;
            @(negedge clock_in);
            check(12'(stat), 12'h0);
            sr = 1'b0;
            @(negedge clock_in);
            check(12'(stat), 12'(r.st));
            check(12'(br), 12'(r.hs && r.st == SBRB_STAT_MOD_HIT));
            @(negedge clock_in);
            check(12'(br), 12'(r.st == SBRB_STAT_MOD_HIT));
            check(12'(stat), 12'(r.st));
            other = 1'b0;
            repeat (2) @(negedge clock_in);
            check(12'(stat), 12'h0);
            if (r.st == SBRB_STAT_MOD_HIT) begin
                gnt_en = 1'b1;
                aack_dly = 4'h2;
                wait_for(0, 1'b1);
                check(12'({gbl_o, cb_act}), 12'h1);
                wait_for(3, 1'b1);
                wait_for(3, 1'b0);
                gnt_en = 1'b0;
            end
            repeat (3) @(negedge clock_in);
        end
        // Own transaction retried during address tenure, then blocked and reissued
        half_speed_in = 1'b0;
        aack_dly = 4'h0;
        gnt_en = 1'b1;
        req_in = '{1'b1, 1'b1, 1'b0, 1'b1};
        wait_for(0, 1'b1);
        check(12'({gbl_o, abb_o, br}), 12'h6);
        gnt_en = 1'b0;
        retry = 1'b1;
        repeat (2) @(negedge clock_in);
        other = 1'b1;
        check(12'({abb_o, retried, br}), 12'h2);
        repeat (4) @(negedge clock_in);
        check(12'(br), 12'h0);
        retry = 1'b0;
        wait_for(2, 1'b1);
        other = 1'b0;
        aack_dly = 4'h2;
        gnt_en = 1'b1;
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        check(12'({retried, dbb_o}), 12'h0);
        req_in = '0;
        gnt_en = 1'b0;
        repeat (3) @(negedge clock_in);
        // Retry with the bus idle the cycle before must not block the request
        req_in = '{1'b1, 1'b1, 1'b0, 1'b1};
        wait_for(2, 1'b1);
        retry = 1'b1;
        repeat (3) @(negedge clock_in);
        check(12'(br), 12'h1);
        retry = 1'b0;
        gnt_en = 1'b1;
        wait_for(1, 1'b1);
        // Split bus: retry before address ack keeps the bus, retry after it ends the tenure
        req_in = '{1'b1, 1'b1, 1'b1, 1'b1};
        aack_dly = 4'h3;
        wait_for(0, 1'b1);
        gnt_en = 1'b0;
        retry = 1'b1;
        repeat (2) @(negedge clock_in);
        check(12'({abb_o, retried}), 12'h2);
        repeat (3) @(negedge clock_in);
        check(12'({abb_o, retried}), 12'h1);
        retry = 1'b0;
        other = 1'b1;
        @(negedge clock_in);
        other = 1'b0;
        gnt_en = 1'b1;
        wait_for(1, 1'b1);
        req_in = '0;
        conclude();
    end
endmodule : snoop_bus_request_blocking_tb_top
`default_nettype wire
